/* hdl/pwm_timer.sv */
// Notes on behaviour
// - the timer counts only while the clock-supply enable bit is 1, otherwise it is frozen.
// - each channel picks its count clock: base clock, base/2, /4, /8, /32, fast clock or external pin.
// - the external count-clock pin counts only while the external-clock enable bit is 1.
// - the fast clock is the system clock when the strap is 0 and the fast oscillator when it is 1.
// - one pwm period lasts period value plus one count-clock cycles.
// - each pin is active for period value minus duty value count-clock cycles per period.
// - each pin is inactive for duty value plus one count-clock cycles per period.
// - writing 1 to a channel's start bit starts its count.
// - with stop select 1, writing 0 to the start bit stops the count and pins keep their level.
// - with stop select 0, the count stops itself at the period match and pins hold the match level.
// - two identical channels each with their own counter, period, duty and control bits.
`timescale 1ns/1ps
`include "pwm_timer_params.svh"
module pwm_timer
   import pwm_timer_pkg::*;
(
   // clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       srst,
   // register port
   input  wire reg_req_s                   reg_req,
   output logic [`DATA_W-1:0]              reg_rdata,
   // count clock sources
   input  wire logic                       fast_osc_tick,
   input  wire logic                       fast_clock_source_select,
   input  wire logic                       ext_count_clock_pin,
   // outputs
   output logic [`NUM_CH*`NUM_PIN-1:0]     pwm_pins,
   output logic                            irq
);

   state_s                          st_reg;
   state_s                          st_next;
   logic [`NUM_CH-1:0]              tick;
   logic [`NUM_CH*`ST_STRIDE-1:0]   evt;
   logic [`NUM_CH*`ST_STRIDE-1:0]   clr;
   logic                            ext_edge;
   logic                            fast_src;
   logic [1:0]                      ch_idx;
   logic [4:0]                      ch_ofs;
   logic                            ch_hit;
   logic                            per_match;

   assign reg_rdata = st_reg.rdata;
   assign irq       = st_reg.irq;

   always_comb begin
      for (int i = 0; i < `NUM_CH; i++) begin
         pwm_pins[i*`NUM_PIN +: `NUM_PIN] = st_reg.chan[i].pwm;
      end
   end

   always_comb begin
      st_next   = st_reg;
      evt       = '0;
      clr       = '0;
      tick      = '0;
      per_match = 1'b0;
      ch_idx    = {1'b0, reg_req.addr[5]};
      ch_ofs    = reg_req.addr[4:0];
      ch_hit    = (reg_req.addr[7:6] == `CH_REGION);

      // strap caught once after reset release
      if (!st_reg.strap_done) begin
         st_next.strap      = fast_clock_source_select;
         st_next.strap_done = 1'b1;
      end

      // prescaler and external edge
      if (st_reg.supply_en) begin
         st_next.presc = st_reg.presc + 5'h01;
      end
      st_next.ext_q = ext_count_clock_pin;
      ext_edge      = ext_count_clock_pin & ~st_reg.ext_q;
      fast_src      = st_reg.strap ? fast_osc_tick : 1'b1;

      // channels
      for (int i = 0; i < `NUM_CH; i++) begin
         case (st_reg.chan[i].clk_sel)
            CLK_DIV1:  tick[i] = 1'b1;
            CLK_DIV2:  tick[i] = st_reg.presc[0];
            CLK_DIV4:  tick[i] = &st_reg.presc[1:0];
            CLK_DIV8:  tick[i] = &st_reg.presc[2:0];
            CLK_DIV32: tick[i] = &st_reg.presc[4:0];
            CLK_FAST:  tick[i] = fast_src;
            CLK_EXT:   tick[i] = st_reg.ext_en & ext_edge;
            default:   tick[i] = 1'b0;
         endcase
         tick[i] = tick[i] & st_reg.supply_en;

         if (st_reg.chan[i].run && tick[i]) begin
            per_match = (st_reg.chan[i].cnt == st_reg.chan[i].period);
            if (per_match) begin
               st_next.chan[i].cnt = '0;
               evt[i*`ST_STRIDE + `ST_PERIOD] = 1'b1;
               if (!st_reg.chan[i].stop_sel) begin
                  st_next.chan[i].run = 1'b0;
               end
            end else begin
               st_next.chan[i].cnt = st_reg.chan[i].cnt + 16'h0001;
               if (&st_reg.chan[i].cnt) begin
                  evt[i*`ST_STRIDE + `ST_OVF] = 1'b1;
               end
            end
            for (int j = 0; j < `NUM_PIN; j++) begin
               if (per_match) begin
                  st_next.chan[i].pwm[j] = 1'b0;
               end else if (st_reg.chan[i].cnt == st_reg.chan[i].duty[j]) begin
                  st_next.chan[i].pwm[j] = 1'b1;
               end
               if (st_reg.chan[i].cnt == st_reg.chan[i].duty[j]) begin
                  evt[i*`ST_STRIDE + `ST_DUTY0 + j] = 1'b1;
               end
            end
         end
      end

      // register writes
      if (reg_req.wr) begin
         if (ch_hit) begin
            case (ch_ofs)
               `OFS_CH_COUNT:  st_next.chan[ch_idx].cnt     = reg_req.wdata[`CNT_W-1:0];
               `OFS_CH_PERIOD: st_next.chan[ch_idx].period  = reg_req.wdata[`CNT_W-1:0];
               `OFS_CH_DUTY0:  st_next.chan[ch_idx].duty[0] = reg_req.wdata[`CNT_W-1:0];
               `OFS_CH_DUTY1:  st_next.chan[ch_idx].duty[1] = reg_req.wdata[`CNT_W-1:0];
               `OFS_CH_DUTY2:  st_next.chan[ch_idx].duty[2] = reg_req.wdata[`CNT_W-1:0];
               default: ;
            endcase
         end else begin
            case (reg_req.addr)
               `OFS_PERIPH_EN: st_next.supply_en = reg_req.wdata[`BIT_SUPPLY_EN];
               `OFS_FUNC_CTRL: st_next.ext_en    = reg_req.wdata[`BIT_EXT_EN];
               `OFS_START_CTRL: begin
                  for (int i = 0; i < `NUM_CH; i++) begin
                     st_next.chan[i].stop_sel = reg_req.wdata[`BIT_STOPSEL0 + i];
                     if (reg_req.wdata[`BIT_START0 + i]) begin
                        st_next.chan[i].run = 1'b1;
                     end else if (st_reg.chan[i].stop_sel) begin
                        st_next.chan[i].run = 1'b0;
                     end
                  end
               end
               `OFS_CLK_SEL: begin
                  for (int i = 0; i < `NUM_CH; i++) begin
                     st_next.chan[i].clk_sel = clk_sel_e'(reg_req.wdata[i*`CLKSEL_STRIDE +: 3]);
                  end
               end
               `OFS_STATUS: clr = reg_req.wdata[`NUM_CH*`ST_STRIDE-1:0];
               `OFS_MASK:   st_next.mask = reg_req.wdata[`NUM_CH*`ST_STRIDE-1:0];
               default: ;
            endcase
         end
      end

      // sticky status, set wins over clear
      st_next.status = (st_reg.status & ~clr) | evt;
      st_next.irq    = |(st_reg.status & st_reg.mask);

      // read data, valid for one cycle only
      st_next.rdata = '0;
      if (reg_req.rd) begin
         if (ch_hit) begin
            case (ch_ofs)
               `OFS_CH_COUNT:  st_next.rdata = {16'h0000, st_reg.chan[ch_idx].cnt};
               `OFS_CH_PERIOD: st_next.rdata = {16'h0000, st_reg.chan[ch_idx].period};
               `OFS_CH_DUTY0:  st_next.rdata = {16'h0000, st_reg.chan[ch_idx].duty[0]};
               `OFS_CH_DUTY1:  st_next.rdata = {16'h0000, st_reg.chan[ch_idx].duty[1]};
               `OFS_CH_DUTY2:  st_next.rdata = {16'h0000, st_reg.chan[ch_idx].duty[2]};
               default:        st_next.rdata = '0;
            endcase
         end else begin
            case (reg_req.addr)
               `OFS_PERIPH_EN:  st_next.rdata = {31'h00000000, st_reg.supply_en};
               `OFS_FUNC_CTRL:  st_next.rdata = {31'h00000000, st_reg.ext_en};
               `OFS_START_CTRL: st_next.rdata = {28'h0000000, st_reg.chan[1].stop_sel, st_reg.chan[0].stop_sel,
                                                 st_reg.chan[1].run, st_reg.chan[0].run};
               `OFS_CLK_SEL:    st_next.rdata = {25'h0000000, st_reg.chan[1].clk_sel, 1'b0,
                                                 st_reg.chan[0].clk_sel};
               `OFS_STATUS:     st_next.rdata = {16'h0000, st_reg.status};
               `OFS_MASK:       st_next.rdata = {16'h0000, st_reg.mask};
               default:         st_next.rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_reg <= '0;
         for (int i = 0; i < `NUM_CH; i++) begin
            st_reg.chan[i].period <= `PERIOD_RST;
            for (int j = 0; j < `NUM_PIN; j++) begin
               st_reg.chan[i].duty[j] <= `DUTY_RST;
            end
         end
      end else begin
         st_reg <= st_next;
      end
   end

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   // clock supply and count clock
   a_supply_freeze: assert property (!st_reg.supply_en |-> !tick[0] && !tick[1])
      else $error("count tick without clock supply");

   a_presc_hold: assert property (!st_reg.supply_en |=> $stable(st_reg.presc))
      else $error("prescaler moved without clock supply");

   a_div2_spacing: assert property (tick[1] && st_reg.chan[1].clk_sel == CLK_DIV2 &&
                                    $stable(st_reg.chan[1].clk_sel) &&
                                    !(reg_req.wr && reg_req.addr == `OFS_CLK_SEL) |=> !tick[1])
      else $error("divide-by-2 tick came twice in a row");

   a_div4_spacing: assert property (tick[1] && st_reg.chan[1].clk_sel == CLK_DIV4 &&
                                    !(reg_req.wr && reg_req.addr == `OFS_CLK_SEL) |=> !tick[1] [*3])
      else $error("divide-by-4 tick came too soon");

   a_ext_gated: assert property (tick[1] && st_reg.chan[1].clk_sel == CLK_EXT |->
                                 st_reg.ext_en && ext_count_clock_pin && !$past(ext_count_clock_pin))
      else $error("external tick without enabled rising edge");

   a_fast_sysclk: assert property (st_reg.strap_done && !st_reg.strap && st_reg.supply_en &&
                                   st_reg.chan[1].clk_sel == CLK_FAST |-> tick[1])
      else $error("fast clock on system clock did not tick");

   a_fast_osc: assert property (st_reg.strap_done && st_reg.strap &&
                                st_reg.chan[1].clk_sel == CLK_FAST |-> tick[1] == (fast_osc_tick && st_reg.supply_en))
      else $error("fast clock did not follow the oscillator");

   a_strap_hold: assert property (st_reg.strap_done |=> $stable(st_reg.strap))
      else $error("strap changed after capture");

   // counter and pins
   a_period_wrap: assert property (st_reg.chan[0].run && tick[0] && !reg_req.wr &&
                                   st_reg.chan[0].cnt == st_reg.chan[0].period
                                   |=> st_reg.chan[0].cnt == 16'h0000)
      else $error("counter did not restart after period match");

   a_step_one: assert property (st_reg.chan[0].run && tick[0] && !reg_req.wr &&
                                st_reg.chan[0].cnt != st_reg.chan[0].period
                                |=> st_reg.chan[0].cnt == $past(st_reg.chan[0].cnt) + 16'h0001)
      else $error("counter did not step by one");

   a_ch1_step: assert property (st_reg.chan[1].run && tick[1] && !reg_req.wr &&
                                st_reg.chan[1].cnt != st_reg.chan[1].period
                                |=> st_reg.chan[1].cnt == $past(st_reg.chan[1].cnt) + 16'h0001)
      else $error("second counter did not step by one");

   a_duty_active: assert property (st_reg.chan[0].run && tick[0] &&
                                   st_reg.chan[0].cnt == st_reg.chan[0].duty[0] &&
                                   st_reg.chan[0].cnt != st_reg.chan[0].period |=> st_reg.chan[0].pwm[0])
      else $error("pin did not go active at duty match");

   a_ch1_active: assert property (st_reg.chan[1].run && tick[1] &&
                                  st_reg.chan[1].cnt == st_reg.chan[1].duty[0] &&
                                  st_reg.chan[1].cnt != st_reg.chan[1].period |=> st_reg.chan[1].pwm[0])
      else $error("second channel pin did not go active");

   a_period_inactive: assert property (st_reg.chan[0].run && tick[0] &&
                                       st_reg.chan[0].cnt == st_reg.chan[0].period
                                       |=> st_reg.chan[0].pwm == 3'h0)
      else $error("pins not inactive after period match");

   a_ch1_inactive: assert property (st_reg.chan[1].run && tick[1] &&
                                    st_reg.chan[1].cnt == st_reg.chan[1].period |=> st_reg.chan[1].pwm == 3'h0)
      else $error("second channel pins not inactive");

   a_pin_quiet: assert property ($changed(st_reg.chan[0].pwm) |-> $past(st_reg.chan[0].run && tick[0]))
      else $error("pin moved without a count tick");

   a_ch1_quiet: assert property ($changed(st_reg.chan[1].pwm) |-> $past(st_reg.chan[1].run && tick[1]))
      else $error("second channel pin moved without a tick");

   // start and stop, and second channel restart
   a_start_write: assert property (reg_req.wr && reg_req.addr == `OFS_START_CTRL && reg_req.wdata[0]
                                   |=> st_reg.chan[0].run)
      else $error("start write did not start the count");

   a_ch1_start: assert property (reg_req.wr && reg_req.addr == `OFS_START_CTRL && reg_req.wdata[1]
                                 |=> st_reg.chan[1].run)
      else $error("start write did not start the second count");

   a_stop_write: assert property (reg_req.wr && reg_req.addr == `OFS_START_CTRL && !reg_req.wdata[0] &&
                                  st_reg.chan[0].stop_sel |=> !st_reg.chan[0].run)
      else $error("stop write did not stop the count");

   a_ch1_stop: assert property (reg_req.wr && reg_req.addr == `OFS_START_CTRL && !reg_req.wdata[1] &&
                                st_reg.chan[1].stop_sel |=> !st_reg.chan[1].run)
      else $error("stop write did not stop the second count");

   a_stop_hold: assert property (!st_reg.chan[0].run ##1 !st_reg.chan[0].run
                                 |-> $stable(st_reg.chan[0].pwm))
      else $error("pin changed while stopped");

   a_ch1_hold: assert property (!st_reg.chan[1].run ##1 !st_reg.chan[1].run
                                |-> $stable(st_reg.chan[1].pwm))
      else $error("second channel pin changed while stopped");

   a_auto_stop: assert property (st_reg.chan[0].run && !st_reg.chan[0].stop_sel && tick[0] && !reg_req.wr &&
                                 st_reg.chan[0].cnt == st_reg.chan[0].period |=> !st_reg.chan[0].run)
      else $error("count did not stop itself at period match");

   a_stop_ignored: assert property (reg_req.wr && reg_req.addr == `OFS_START_CTRL && !reg_req.wdata[0] &&
                                    !st_reg.chan[0].stop_sel && st_reg.chan[0].run &&
                                    !(tick[0] && st_reg.chan[0].cnt == st_reg.chan[0].period) |=> st_reg.chan[0].run)
      else $error("stop write acted without stop select");

   a_chan1_wrap: assert property (st_reg.chan[1].run && tick[1] && !reg_req.wr &&
                                  st_reg.chan[1].cnt == st_reg.chan[1].period
                                  |=> st_reg.chan[1].cnt == 16'h0000)
      else $error("second channel did not restart");

   // interrupts
   a_ovf_event: assert property (st_reg.chan[1].run && tick[1] && st_reg.chan[1].cnt == 16'hffff &&
                                 st_reg.chan[1].cnt != st_reg.chan[1].period |=> st_reg.status[`ST_STRIDE + `ST_OVF])
      else $error("overflow did not set its status bit");

   a_duty_event: assert property (st_reg.chan[1].run && tick[1] &&
                                  st_reg.chan[1].cnt == st_reg.chan[1].duty[0] |=> st_reg.status[`ST_STRIDE + `ST_DUTY0])
      else $error("duty match did not set its status bit");

   a_duty2_event: assert property (st_reg.chan[0].run && tick[0] &&
                                   st_reg.chan[0].cnt == st_reg.chan[0].duty[2] |=> st_reg.status[`ST_DUTY0 + 2])
      else $error("third duty match did not set its status bit");

   a_status_sticky: assert property (st_reg.status[`ST_PERIOD] &&
                                     !(reg_req.wr && reg_req.addr == `OFS_STATUS && reg_req.wdata[`ST_PERIOD])
                                     |=> st_reg.status[`ST_PERIOD])
      else $error("status bit dropped without a clear");

   a_status_clear: assert property (reg_req.wr && reg_req.addr == `OFS_STATUS && reg_req.wdata[`ST_PERIOD] &&
                                    !evt[`ST_PERIOD] |=> !st_reg.status[`ST_PERIOD])
      else $error("status bit not cleared by a one");

   a_irq_follow: assert property (irq == $past(|(st_reg.status & st_reg.mask)))
      else $error("interrupt does not follow masked status");

   a_irq_masked: assert property (!(|st_reg.mask) |=> !irq)
      else $error("interrupt with every source masked");

   a_irq_level: assert property (st_reg.chan[0].run && tick[0] && st_reg.chan[0].cnt == st_reg.chan[0].period &&
                                 st_reg.mask[`ST_PERIOD] && !(reg_req.wr && reg_req.addr == `OFS_MASK) |-> ##2 irq)
      else $error("period match did not raise interrupt");

   c_auto_stop: cover property (st_reg.chan[0].run && !st_reg.chan[0].stop_sel ##1 !st_reg.chan[0].run);
   c_pwm_rise:  cover property (!st_reg.chan[0].pwm[0] ##1 st_reg.chan[0].pwm[0]);
   c_overflow:  cover property (st_reg.status[`ST_STRIDE + `ST_OVF]);
   c_irq:       cover property (irq);
   c_ext_tick:  cover property (tick[1] && st_reg.chan[1].clk_sel == CLK_EXT);

endmodule

/* common/pwm_timer_params.svh */
`ifndef PWM_TIMER_PARAMS_SVH
`define PWM_TIMER_PARAMS_SVH

// widths
`define CNT_W           16
`define ADDR_W          8
`define DATA_W          32
`define PRESC_W         5
`define NUM_CH          2
`define NUM_PIN         3

// global register byte offsets
`define OFS_PERIPH_EN   8'h00
`define OFS_START_CTRL  8'h04
`define OFS_FUNC_CTRL   8'h08
`define OFS_CLK_SEL     8'h0c
`define OFS_STATUS      8'h10
`define OFS_MASK        8'h14

// channel windows: base + channel * stride
`define CH_REGION       2'b01
`define OFS_CH_COUNT    5'h00
`define OFS_CH_PERIOD   5'h04
`define OFS_CH_DUTY0    5'h08
`define OFS_CH_DUTY1    5'h0c
`define OFS_CH_DUTY2    5'h10

// field positions
`define BIT_SUPPLY_EN   0
`define BIT_EXT_EN      0
`define BIT_START0      0
`define BIT_STOPSEL0    2
`define CLKSEL_STRIDE   4
`define ST_STRIDE       8
`define ST_PERIOD       0
`define ST_DUTY0        1
`define ST_OVF          4

// reset values
`define PERIOD_RST      16'hffff
`define DUTY_RST        16'hffff

`endif

/* common/pwm_timer_pkg.sv */
package pwm_timer_pkg;
`include "pwm_timer_params.svh"

   typedef enum logic [2:0] {
      CLK_DIV1  = 3'b000,
      CLK_DIV2  = 3'b001,
      CLK_DIV4  = 3'b010,
      CLK_DIV8  = 3'b011,
      CLK_DIV32 = 3'b100,
      CLK_FAST  = 3'b101,
      CLK_EXT   = 3'b110
   } clk_sel_e;

   typedef struct packed {
      logic [`ADDR_W-1:0] addr;
      logic [`DATA_W-1:0] wdata;
      logic               wr;
      logic               rd;
   } reg_req_s;

   typedef struct packed {
      logic                             run;
      logic                             stop_sel;
      clk_sel_e                         clk_sel;
      logic [`CNT_W-1:0]                cnt;
      logic [`CNT_W-1:0]                period;
      logic [`NUM_PIN-1:0][`CNT_W-1:0]  duty;
      logic [`NUM_PIN-1:0]              pwm;
   } chan_s;

   typedef struct packed {
      logic                             supply_en;
      logic                             ext_en;
      logic                             strap;
      logic                             strap_done;
      logic [`PRESC_W-1:0]              presc;
      logic                             ext_q;
      logic [`NUM_CH-1:0]               ext_dummy;
      chan_s [`NUM_CH-1:0]              chan;
      logic [`NUM_CH*`ST_STRIDE-1:0]    status;
      logic [`NUM_CH*`ST_STRIDE-1:0]    mask;
      logic [`DATA_W-1:0]               rdata;
      logic                             irq;
   } state_s;

endpackage

/* bench/testbench.sv */
`timescale 1ns/1ps
`include "pwm_timer_params.svh"
module testbench;
   import pwm_timer_pkg::*;

   typedef struct {
      logic [31:0] exp;
      int          tol;
   } note_s;

   logic                        sys_clk;
   logic                        srst;
   reg_req_s                    reg_req;
   logic [`DATA_W-1:0]          reg_rdata;
   logic                        fast_osc_tick;
   logic                        fast_clock_source_select;
   logic                        ext_count_clock_pin;
   logic [`NUM_CH*`NUM_PIN-1:0] pwm_pins;
   logic                        irq;
   logic                        rd_q;
   logic                        ext_run;
   logic [2:0]                  held;
   int                          bad_count;
   int                          samples_checked;
   int                          cyc;
   int                          m;
   int                          n0;
   int                          hi;
   int                          dv[5] = '{1, 2, 4, 8, 32};
   note_s                       notes[$];

   pwm_timer dut (
      .sys_clk                  (sys_clk),
      .srst                     (srst),
      .reg_req                  (reg_req),
      .reg_rdata                (reg_rdata),
      .fast_osc_tick            (fast_osc_tick),
      .fast_clock_source_select (fast_clock_source_select),
      .ext_count_clock_pin      (ext_count_clock_pin),
      .pwm_pins                 (pwm_pins),
      .irq                      (irq)
   );

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // count clock sources, read tracking and hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      fast_osc_tick <= (cyc % 4 == 3);
      if (ext_run && cyc % 2 == 0) ext_count_clock_pin <= ~ext_count_clock_pin;
      rd_q <= reg_req.rd;
      if (cyc == 20000) begin
         bad_count++;
         end_sim();
      end
   end

   // read data stands in the cycle after the strobe only
   always @(negedge sys_clk) begin
      if (rd_q === 1'b1 && notes.size() > 0) check_rd(notes.pop_front(), reg_rdata);
   end

   task automatic check_rd(input note_s e, input logic [31:0] got);
      logic ok;
      ok = got >= e.exp - e.tol && got <= e.exp + e.tol;
      samples_checked++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("unexpected read data expected %h seen %h", e.exp, got);
      end
   endtask

   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_req.addr <= a;
      reg_req.wdata <= d;
      reg_req.wr <= 1'b1;
      @(posedge sys_clk);
      reg_req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input int tol);
      @(posedge sys_clk);
      reg_req.addr <= a;
      reg_req.rd <= 1'b1;
      notes.push_back('{exp, tol});
      @(posedge sys_clk);
      reg_req.rd <= 1'b0;
   endtask

   function automatic logic [7:0] ch(input int i, input int ofs);
      return 8'(8'h40 + i * 32 + ofs);
   endfunction

   task automatic cycles(input int k);
      repeat (k) @(posedge sys_clk);
   endtask

   task automatic done(input string t);
      $display("test %s finished", t);
   endtask

   // channel 1 runs a fixed window on the chosen count clock
   task automatic run_div(input logic [31:0] sel, input logic [31:0] exp, input int tol);
      wr(ch(1, `OFS_CH_COUNT), 32'h0);
      wr(`OFS_CLK_SEL, sel << 4);
      wr(`OFS_START_CTRL, 32'ha);
      cycles(256);
      wr(`OFS_START_CTRL, 32'h8);
      rd(ch(1, `OFS_CH_COUNT), exp, tol);
   endtask

   task automatic count_high(input int j, input int w, output int h);
      h = 0;
      repeat (w) begin
         @(negedge sys_clk);
         h += int'(pwm_pins[j] === 1'b1);
      end
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      srst = 1'b1;
      reg_req = '0;
      fast_osc_tick = 1'b0;
      fast_clock_source_select = 1'b0;
      ext_count_clock_pin = 1'b0;
      ext_run = 1'b0;
      rd_q = 1'b0;
      cyc = 0;
      bad_count = 0;
      samples_checked = 0;
      void'($urandom(32'h4e01));
      cycles(12);
      srst <= 1'b0;
      wr(8'h30, 32'hffff_ffff);
      rd(8'h30, 32'h0, 0);
      rd(ch(0, `OFS_CH_PERIOD), 32'(`PERIOD_RST), 0);
      rd(ch(1, `OFS_CH_DUTY2), 32'(`DUTY_RST), 0);
      run_div(0, 0, 0);
      done("reset and supply");
      wr(`OFS_PERIPH_EN, 32'h1);
      m = 4 + $urandom % 17;
      n0 = $urandom % m;
      wr(ch(0, `OFS_CH_PERIOD), m);
      wr(ch(0, `OFS_CH_DUTY0), n0);
      wr(ch(0, `OFS_CH_DUTY1), 0);
      wr(ch(0, `OFS_CH_DUTY2), m);
      wr(`OFS_START_CTRL, 32'h5);
      cycles(2 * (m + 1));
      for (int j = 0; j < 3; j++) begin
         count_high(j, 10 * (m + 1), hi);
         check_val("pin high cycles", 10 * (m - (j == 0 ? n0 : j == 1 ? 0 : m)), hi);
      end
      done("pwm widths");
      wr(`OFS_START_CTRL, 32'h4);
      cycles(3);
      held = pwm_pins[2:0];
      hi = 0;
      repeat (20) begin
         @(negedge sys_clk);
         hi += int'(pwm_pins[2:0] !== held);
      end
      check_val("pin changes after stop", 0, hi);
      wr(ch(0, `OFS_CH_COUNT), 32'h1234);
      cycles(10);
      rd(ch(0, `OFS_CH_COUNT), 32'h1234, 0);
      rd(`OFS_START_CTRL, 32'h4, 0);
      wr(ch(0, `OFS_CH_PERIOD), 32'd40);
      wr(ch(0, `OFS_CH_COUNT), 32'h0);
      wr(`OFS_START_CTRL, 32'h1);
      wr(`OFS_START_CTRL, 32'h0);
      rd(`OFS_START_CTRL, 32'h1, 0);
      cycles(60);
      rd(`OFS_START_CTRL, 32'h0, 0);
      rd(ch(0, `OFS_CH_COUNT), 32'h0, 0);
      check_val("pins after auto stop", 0, pwm_pins[2:0]);
      done("stop modes");
      wr(`OFS_MASK, 32'h0);
      wr(`OFS_STATUS, 32'hffff_ffff);
      rd(`OFS_STATUS, 32'h0, 0);
      wr(`OFS_MASK, 32'h1);
      check_val("irq", 0, irq);
      for (int j = 0; j < 3; j++) wr(ch(0, `OFS_CH_DUTY0 + 4 * j), 32'hffff);
      wr(ch(0, `OFS_CH_PERIOD), 32'h5);
      wr(`OFS_START_CTRL, 32'h1);
      cycles(12);
      rd(`OFS_STATUS, 32'h1, 0);
      check_val("irq", 1, irq);
      wr(`OFS_MASK, 32'h0);
      cycles(3);
      check_val("irq", 0, irq);
      wr(`OFS_MASK, 32'h1);
      cycles(3);
      check_val("irq", 1, irq);
      wr(`OFS_STATUS, 32'h1);
      cycles(3);
      check_val("irq", 0, irq);
      for (int j = 0; j < 3; j++) wr(ch(1, `OFS_CH_DUTY0 + 4 * j), 32'h8);
      wr(ch(1, `OFS_CH_PERIOD), 32'h10);
      wr(ch(1, `OFS_CH_COUNT), 32'hfff0);
      wr(`OFS_START_CTRL, 32'ha);
      cycles(40);
      for (int j = 3; j < 6; j++) begin
         count_high(j, 170, hi);
         check_val("ch1 pin high cycles", 80, hi);
      end
      wr(`OFS_START_CTRL, 32'h8);
      rd(`OFS_STATUS, 32'h1f00, 0);
      wr(`OFS_MASK, 32'h1000);
      cycles(3);
      check_val("irq", 1, irq);
      done("interrupts");
      wr(ch(1, `OFS_CH_PERIOD), 32'hffff);
      for (int k = 0; k < 5; k++) run_div(k, 256 / dv[k], 3);
      run_div(5, 256, 3);
      run_div(6, 0, 0);
      run_div(7, 0, 0);
      wr(`OFS_FUNC_CTRL, 32'h1);
      ext_run <= 1'b1;
      run_div(6, 64, 3);
      fast_clock_source_select <= 1'b1;
      srst <= 1'b1;
      cycles(2);
      srst <= 1'b0;
      wr(`OFS_PERIPH_EN, 32'h1);
      run_div(5, 64, 3);
      done("count clocks");
      cycles(4);
      end_sim();
   end
endmodule
